// ---- logic/ssd_pkg.sv ----
// package: constants for the stepper status and diagnostic block
package ssd_pkg;
    localparam int          WORD_BITS       = 16;
    localparam logic [3:0]  DIAGNOSTIC_PIN_ADDR       = 4'hF;
    localparam logic [3:0]  SYSCTL_ADDR     = 4'h6;
    localparam logic [3:0]  DIAGCFG_ADDR    = 4'h3;
    localparam logic [3:0]  MASK_ADDR       = 4'hE;
    localparam logic [4:0]  HEAD_BITS       = 5'h05;
    localparam logic [4:0]  LAST_EDGE       = 5'h10;
    // status word bit positions
    localparam int          ST_FF           = 15;
    localparam int          ST_POR          = 14;
    localparam int          ST_SE           = 13;
    localparam int          ST_CR           = 12;
    localparam int          ST_SSA          = 11;
    localparam int          ST_OT           = 10;
    localparam int          ST_TW           = 9;
    localparam int          ST_OV           = 8;
    localparam int          ST_UV           = 7;
    localparam int          ST_OLB          = 4;
    localparam int          ST_OLA          = 3;
    localparam int          ST_OCB          = 2;
    localparam int          ST_OCA          = 1;
    // system control field positions (data bits 10:1 of register 6)
    localparam int          SC_SLEEP        = 10;
    localparam int          SC_FRST         = 9;
    localparam int          SC_DSR          = 4;
    // diagnostic pin select field (register 3 bits 9:7)
    localparam int          DSG_HI          = 9;
    localparam int          DSG_LO          = 7;
    localparam logic [2:0]  DSG_GENERAL     = 3'h0;
    localparam logic [2:0]  DSG_MOTION      = 3'h6;
    localparam logic [9:0]  SYSCTL_RESET    = 10'h020;
    localparam logic [9:0]  DIAGCFG_RESET   = 10'h009;
    localparam logic [9:0]  MASK_RESET      = 10'h000;
    localparam logic [9:0]  ZERO10          = 10'h000;
    localparam logic [7:0]  ZERO8           = 8'h00;
    // monitors: OT, TW, OV, UV, OPEN_LOAD_PHASE_B, OPEN_LOAD_PHASE_A
    localparam int          NMON            = 6;
endpackage

// ---- logic/ssd_sync.sv ----
// three-stage synchroniser for pin inputs with agreement filter
`timescale 1ns/100ps
`default_nettype none
module ssd_sync
    import ssd_pkg::*;
#(
    parameter logic        RESET_VAL = 1'b0
) (
    input  wire logic      i_clk,
    input  wire logic      i_sys_rst,
    input  wire logic      i_async,
    output logic           o_level
);
    logic [2:0] stage_reg;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            stage_reg <= {3{RESET_VAL}};
        end else begin
            stage_reg <= {stage_reg[1:0], i_async};
        end
    end

    // first stage is read only by the second
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_level <= RESET_VAL;
        end else if (stage_reg[1] == stage_reg[2]) begin
            o_level <= stage_reg[2];
        end
    end
endmodule
`default_nettype wire

// ---- logic/ssd_top.sv ----
// serial status and overcurrent diagnostic logic of a stepper driver
// How it works
// RL1: every transfer shifts out top five status bits first
// RL2: write transfer stores register, answers low ten status bits plus parity
// RL3: read transfer keeps registers, answers addressed register plus parity
// RL4: summary flag is OR of fault bits, excluding ready and active bits
// RL5: summary flag appears on data out as soon as strobe falls
// RL6: strobe low with no clock edges is a clean poll, no error
// RL7: strobe high ends transfer and floats data out
// RL8: power-on sets summary and power-up bits, clears the latched fault bits; ready and active bits follow their inputs
// RL9: bit 13 flags that the previous transfer failed
// RL10: bit 12 shows command ready; profile commands ignored while low
// RL11: bit 11 tracks an active step sequence
// RL12: pin select 110 drives sequence-active state on diagnostic pin
// RL13: diagnostic pin may show summary fault level instead
// RL14: status reset clears only faults that have gone away
// RL15: phase overcurrent bits are OR of the four transistor bits
// RL16: clearing status leaves phase overcurrent bits; detail clear does it
// RL17: write to detail register ignored, status answered instead
// RL18: with serial reset enabled, reading a register clears its faults
// RL19: reset pin pulse or fault reset bit clears latched faults
// RL20: sleep via reset pin or sleep bit clears latched faults
// RL21: every 16-bit word carries odd parity in its last bit
// RL22: wrong edge count discards write and sets serial error
// RL23: a set mask bit fully disables its monitor
// RL24: status bit order fixed from summary flag down to overcurrent A
// RL25: detail register latches one overcurrent bit per transistor
`timescale 1ns/100ps
`default_nettype none
module ssd_top
    import ssd_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_serial_strobe_n,
    input  wire logic       i_serial_clk,
    input  wire logic       i_serial_data_in,
    input  wire logic       i_reset_pin_n,
    input  wire logic [5:0] i_monitor_fault,
    input  wire logic [7:0] i_transistor_oc,
    input  wire logic       i_command_ready,
    input  wire logic       i_sequence_active,
    output logic            o_serial_data_out,
    output logic            o_serial_data_oe_n,
    output logic            o_diagnostic_pin,
    output logic            o_sleep_req,
    output logic            o_profile_accept,
    output logic [9:0]      o_sysctl,
    output logic [9:0]      o_diagcfg
);
    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic strobe_n_s;
    logic sclk_s;
    logic sdi_s;
    logic rstpin_n_s;

    ssd_sync #(.RESET_VAL(1'b1)) u_sync_stb (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   (i_serial_strobe_n),
        .o_level   (strobe_n_s)
    );
    ssd_sync #(.RESET_VAL(1'b0)) u_sync_clk (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   (i_serial_clk),
        .o_level   (sclk_s)
    );
    ssd_sync #(.RESET_VAL(1'b0)) u_sync_sdi (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   (i_serial_data_in),
        .o_level   (sdi_s)
    );
    ssd_sync #(.RESET_VAL(1'b1)) u_sync_rst (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   (i_reset_pin_n),
        .o_level   (rstpin_n_s)
    );

    // ************************************************************
    // edge detection
    // ************************************************************
    logic strobe_n_d_reg;
    logic sclk_d_reg;
    logic rstpin_n_d_reg;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            strobe_n_d_reg <= 1'b1;
            sclk_d_reg     <= 1'b0;
            rstpin_n_d_reg <= 1'b1;
        end else begin
            strobe_n_d_reg <= strobe_n_s;
            sclk_d_reg     <= sclk_s;
            rstpin_n_d_reg <= rstpin_n_s;
        end
    end

    logic frame_start;
    logic frame_end;
    logic sclk_rise;
    logic sclk_fall;
    logic frame_active;
    assign frame_start  = strobe_n_d_reg && !strobe_n_s;
    assign frame_end    = !strobe_n_d_reg && strobe_n_s;
    assign frame_active = !strobe_n_s;
    assign sclk_rise    = frame_active && !sclk_d_reg && sclk_s;
    assign sclk_fall    = frame_active && sclk_d_reg && !sclk_s;

    // ************************************************************
    // register and fault state
    // ************************************************************
    logic [WORD_BITS-1:0] shift_in_reg;
    logic [WORD_BITS-1:0] shift_out_reg;
    logic [5:0]           edge_cnt_reg;
    logic                 wr_seen_reg;
    logic [9:0]           sysctl_reg;
    logic [9:0]           diagcfg_reg;
    logic [9:0]           mask_reg;
    logic [NMON-1:0]      mon_latch_reg;
    logic [7:0]           oc_latch_reg;
    logic                 por_reg;
    logic                 serr_reg;
    logic                 prev_sleep_reg;
    logic                 prev_frst_reg;

    logic [WORD_BITS-1:0] status_word;
    logic [NMON-1:0]      mon_mask;
    logic                 oc_phase_a;
    logic                 oc_phase_b;
    logic                 summary_fault_flag;

    // mask bits 10,9,8,7,4,3 align with status positions of the monitors
    assign mon_mask = {mask_reg[ST_OT-1], mask_reg[ST_TW-1],
                       mask_reg[ST_OV-1], mask_reg[ST_UV-1],
                       mask_reg[ST_OLB-1], mask_reg[ST_OLA-1]};

    assign oc_phase_b = |oc_latch_reg[7:4];   // see RL15
    assign oc_phase_a = |oc_latch_reg[3:0];   // see RL15

    // ready and active bits deliberately left out
    assign summary_fault_flag = por_reg | serr_reg | (|mon_latch_reg)
                              | oc_phase_a | oc_phase_b;   // see RL4

    always_comb begin
        status_word          = '0;   // see RL24
        status_word[ST_FF]   = summary_fault_flag;
        status_word[ST_POR]  = por_reg;
        status_word[ST_SE]   = serr_reg;
        status_word[ST_CR]   = i_command_ready;   // see RL10
        status_word[ST_SSA]  = i_sequence_active; // see RL11
        status_word[ST_OT]   = mon_latch_reg[5];
        status_word[ST_TW]   = mon_latch_reg[4];
        status_word[ST_OV]   = mon_latch_reg[3];
        status_word[ST_UV]   = mon_latch_reg[2];
        status_word[ST_OLB]  = mon_latch_reg[1];
        status_word[ST_OLA]  = mon_latch_reg[0];
        status_word[ST_OCB]  = oc_phase_b;
        status_word[ST_OCA]  = oc_phase_a;
    end

    // ************************************************************
    // frame decode
    // ************************************************************
    logic [3:0] rx_addr;
    logic       rx_wr;
    logic [9:0] rx_data;
    logic       parity_ok;
    logic       frame_good;
    logic       do_write;
    logic       read_status;
    logic       read_diagnostic_pin;
    assign rx_addr   = shift_in_reg[15:12];
    assign rx_wr     = shift_in_reg[11];
    assign rx_data   = shift_in_reg[10:1];
    assign parity_ok = ^shift_in_reg;   // see RL21
    assign frame_good = frame_end && (edge_cnt_reg == 6'(LAST_EDGE))
                      && parity_ok;
    // writes to the read-only detail register are dropped
    assign do_write  = frame_good && rx_wr && (rx_addr != DIAGNOSTIC_PIN_ADDR); // see RL2 RL17
    // register fields sit one below their word bit positions
    assign read_status = frame_good && !sysctl_reg[SC_DSR-1]
                       && rx_wr;   // see RL18
    assign read_diagnostic_pin = frame_good && !sysctl_reg[SC_DSR-1] && !rx_wr
                     && (rx_addr == DIAGNOSTIC_PIN_ADDR);   // see RL18

    // ************************************************************
    // fault clearing sources
    // ************************************************************
    logic frst_rise;
    logic sleep_rise;
    logic pin_clear;
    logic fault_clear;
    assign frst_rise  = do_write && (rx_addr == SYSCTL_ADDR)
                      && rx_data[SC_FRST-1] && !prev_frst_reg;   // see RL19
    assign sleep_rise = do_write && (rx_addr == SYSCTL_ADDR)
                      && rx_data[SC_SLEEP-1] && !prev_sleep_reg; // see RL20
    assign pin_clear  = rstpin_n_d_reg && !rstpin_n_s;   // see RL19 RL20
    assign fault_clear = frst_rise || sleep_rise || pin_clear || !rstpin_n_s;

    // ************************************************************
    // receive shift and edge count
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || frame_start) begin
            shift_in_reg <= '0;
            edge_cnt_reg <= '0;
        end else if (sclk_rise) begin
            shift_in_reg <= {shift_in_reg[WORD_BITS-2:0], sdi_s};
            if (edge_cnt_reg != 6'h3F) begin
                edge_cnt_reg <= edge_cnt_reg + 6'h01;
            end
        end
    end

    // the write bit is known after the fifth rising edge
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || frame_start) begin
            wr_seen_reg <= 1'b0;
        end else if (sclk_rise && edge_cnt_reg == 6'(HEAD_BITS - 5'h01)) begin
            wr_seen_reg <= 1'b1;
        end
    end

    // ************************************************************
    // transmit: summary flag first, tail loaded after the header
    // ************************************************************
    logic [10:0] tail_word;
    logic [9:0]  read_data;
    always_comb begin
        read_data = status_word[10:1];
        if (shift_in_reg[3:0] == DIAGNOSTIC_PIN_ADDR) begin
            read_data = {ZERO10[1:0], oc_latch_reg};
        end else if (shift_in_reg[3:0] == SYSCTL_ADDR) begin
            read_data = sysctl_reg;
        end else if (shift_in_reg[3:0] == DIAGCFG_ADDR) begin
            read_data = diagcfg_reg;
        end else if (shift_in_reg[3:0] == MASK_ADDR) begin
            read_data = mask_reg;
        end
        // at the fifth rise shift_in holds the address, sdi the write bit
        if (sdi_s) begin
            read_data = status_word[10:1];   // see RL2 RL17
        end
        tail_word = {read_data, 1'b0};
        tail_word[0] = ~^{status_word[15:11], read_data};   // see RL21
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst || frame_end) begin
            shift_out_reg <= '0;
        end else if (frame_start) begin
            shift_out_reg <= status_word;   // see RL1 RL5
        end else if (sclk_rise && edge_cnt_reg == 6'(HEAD_BITS - 5'h01)) begin
            // five bits are already out, so the tail goes straight to the top
            shift_out_reg <= {tail_word, ZERO10[4:0]};   // see RL3
        end else if (sclk_fall) begin
            shift_out_reg <= {shift_out_reg[WORD_BITS-2:0], 1'b0};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_serial_data_out  <= 1'b0;
            o_serial_data_oe_n <= 1'b1;
        end else if (frame_active) begin
            o_serial_data_out  <= frame_start ? summary_fault_flag
                                              : shift_out_reg[WORD_BITS-1];
            o_serial_data_oe_n <= 1'b0;   // see RL5
        end else begin
            o_serial_data_out  <= 1'b0;
            o_serial_data_oe_n <= 1'b1;   // see RL7
        end
    end

    // ************************************************************
    // control registers
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            sysctl_reg     <= SYSCTL_RESET;   // see RL8
            diagcfg_reg    <= DIAGCFG_RESET;
            mask_reg       <= MASK_RESET;
            prev_sleep_reg <= 1'b0;
            prev_frst_reg  <= 1'b0;
        end else if (do_write) begin   // see RL22
            if (rx_addr == SYSCTL_ADDR) begin
                sysctl_reg     <= rx_data;
                prev_sleep_reg <= rx_data[SC_SLEEP-1];
                prev_frst_reg  <= rx_data[SC_FRST-1];
            end else if (rx_addr == DIAGCFG_ADDR) begin
                diagcfg_reg <= rx_data;
            end else if (rx_addr == MASK_ADDR) begin
                mask_reg <= rx_data;
            end
        end
    end

    // ************************************************************
    // fault latches: set wins over clear
    // ************************************************************
    logic status_clear;
    assign status_clear = read_status || fault_clear;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            mon_latch_reg <= '0;
        end else begin
            // live faults re-set the latch, so only gone faults clear
            mon_latch_reg <= ((status_clear ? '0 : mon_latch_reg)
                            | i_monitor_fault) & ~mon_mask; // see RL14 RL23
        end
    end

    // status clear alone leaves the transistor bits alone
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            oc_latch_reg <= '0;
        end else begin
            oc_latch_reg <= ((read_diagnostic_pin || fault_clear) ? ZERO8 : oc_latch_reg)
                          | i_transistor_oc;   // see RL25 RL16
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            por_reg <= 1'b1;   // see RL8
        end else if (status_clear) begin
            por_reg <= 1'b0;
        end
    end

    // a clean strobe with no clock is a poll, never an error
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            serr_reg <= 1'b0;
        end else if (frame_end && edge_cnt_reg != '0
                     && (edge_cnt_reg != 6'(LAST_EDGE) || !parity_ok)) begin
            serr_reg <= 1'b1;   // see RL6 RL9 RL22
        end else if (frame_good || fault_clear) begin
            serr_reg <= 1'b0;
        end
    end

    // ************************************************************
    // outputs toward the core
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_diagnostic_pin <= 1'b1;
            o_sleep_req      <= 1'b0;
            o_profile_accept <= 1'b0;
            o_sysctl         <= SYSCTL_RESET;
            o_diagcfg        <= DIAGCFG_RESET;
        end else begin
            if (diagcfg_reg[DSG_HI-1:DSG_LO-1] == DSG_MOTION) begin
                o_diagnostic_pin <= !i_sequence_active;   // see RL12
            end else begin
                o_diagnostic_pin <= !summary_fault_flag;   // see RL13
            end
            o_sleep_req      <= sleep_rise || !rstpin_n_s;
            o_profile_accept <= do_write && i_command_ready; // see RL10
            o_sysctl         <= sysctl_reg;
            o_diagcfg        <= diagcfg_reg;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    float_when_idle_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        strobe_n_s |=> o_serial_data_oe_n) // see RL7
        else $error("data out driven outside a frame");
    flag_first_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        frame_start |=> o_serial_data_out == $past(summary_fault_flag)) // see RL5
        else $error("summary flag not first");
    summary_or_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (serr_reg || por_reg || oc_phase_a) |-> summary_fault_flag) // see RL4
        else $error("summary flag missing");
    poll_no_error_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (frame_end && edge_cnt_reg == '0 && !serr_reg) |=> !serr_reg) // see RL6
        else $error("poll raised serial error");
    bad_count_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (frame_end && edge_cnt_reg != '0 && edge_cnt_reg != 6'(LAST_EDGE))
        |=> serr_reg && $stable(sysctl_reg)) // see RL22
        else $error("bad frame not flagged");
    oc_sticky_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (oc_latch_reg[0] && !read_diagnostic_pin && !fault_clear) |=> oc_phase_a) // see RL16
        else $error("overcurrent summary lost");
    live_fault_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_monitor_fault[5] && !mon_mask[5]) |=> mon_latch_reg[5]) // see RL14
        else $error("live fault cleared");
    mask_off_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        mon_mask[0] |=> !mon_latch_reg[0] || !$past(mon_mask[0])) // see RL23
        else $error("masked monitor latched");
    pin_motion_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (diagcfg_reg[DSG_HI-1:DSG_LO-1] == DSG_MOTION)
        |=> o_diagnostic_pin == !$past(i_sequence_active)) // see RL12
        else $error("diagnostic_pin pin not motion");

    good_write_c: cover property (@(posedge i_clk) do_write);
    poll_c: cover property (@(posedge i_clk) frame_end && edge_cnt_reg == '0);
    diagnostic_pin_read_c: cover property (@(posedge i_clk) read_diagnostic_pin);
endmodule
`default_nettype wire

// ---- testbench/ssd_host.sv ----
// host serial master model that runs frames into the status block
`timescale 1ns/100ps
`default_nettype none
module ssd_host (
    input  wire logic i_sdo,
    input  wire logic i_oe_n,
    output logic      o_stb_n,
    output logic      o_sck,
    output logic      o_sdi
);
    logic oe_low;
    initial begin
        o_stb_n = 1'b1;
        o_sck = 1'b1;
        o_sdi = 1'b0;
        oe_low = 1'b0;
    end
    // clock idles high, so a frame with no edges is a clean poll
    task automatic xfer(input logic [15:0] w, input int n, input bit bp,
                        output logic [15:0] r);
        w[0] = ~^w[15:1] ^ bp;
        r = '0;
        o_stb_n <= 1'b0;
        #125.3;
        oe_low = !i_oe_n;
        r[15] = i_sdo;
        for (int k = 0; k < n; k++) begin
            o_sck <= 1'b0;
            o_sdi <= w[4'(15 - k)];
            #62.5;
            o_sck <= 1'b1;
            #62.5;
            if (k < 15) r[14-k] = i_sdo;
        end
        o_stb_n <= 1'b1;
        // a released line must not keep showing the last bit
        o_sdi <= !o_sdi;
    endtask
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the stepper status block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        i_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic        stb_n, sck, serial_data_in, serial_data_out, oe_n, dpin, slp, pa;
    logic        rpin_n = 1'b1, cr = 1'b0, sa = 1'b0;
    logic [5:0]  mon = '0, lm = '0;
    logic [7:0]  oc = '0, lo = '0;
    logic [9:0]  sysc, dcfg, msk = '0, dcfg_m = 10'h009, sc_m = 10'h020;
    logic        por_m = 1'b1, se_m = 1'b0;
    logic [15:0] r, e;
    int          n_mismatch = 0, n_checks = 0, n_sl = 0, seed = 44;
    int          n_pa = 0, n_pa_m = 0;
    int          bad[3] = '{15, 17, 16};
    always #5 i_clk = ~i_clk;
    ssd_top ssd_top_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_serial_strobe_n(stb_n), .i_serial_clk(sck),
        .i_serial_data_in(serial_data_in), .i_reset_pin_n(rpin_n),
        .i_monitor_fault(mon), .i_transistor_oc(oc),
        .i_command_ready(cr), .i_sequence_active(sa),
        .o_serial_data_out(serial_data_out), .o_serial_data_oe_n(oe_n),
        .o_diagnostic_pin(dpin), .o_sleep_req(slp),
        .o_profile_accept(pa), .o_sysctl(sysc), .o_diagcfg(dcfg));
    ssd_host ssd_host_i (.i_sdo(serial_data_out), .i_oe_n(oe_n), .o_stb_n(stb_n),
        .o_sck(sck), .o_sdi(serial_data_in));
    // ********
    // reference model
    // ********
    always @(posedge i_clk) begin
        lm <= (lm | mon) & ~{msk[9:6], msk[3:2]};
        lo <= lo | oc;
        if (slp) n_sl <= n_sl + 1;
        if (pa) n_pa <= n_pa + 1;
    end
    function automatic logic [15:0] st();
        logic [15:0] s;
        s = '0;
        {s[14:7], s[4:1]} = {por_m, se_m, cr, sa, lm, |lo[7:4], |lo[3:0]};
        s[15] = |{s[14:13], s[10:1]};
        return s;
    endfunction
    // live faults re-latch at once, so only resolved ones go away
    task automatic clr(input bit all);
        lm = mon & ~{msk[9:6], msk[3:2]};
        por_m = 1'b0;
        if (all) begin
            lo = oc;
            se_m = 1'b0;
        end
    endtask
    task automatic chk_w(input logic [15:0] g, input logic [15:0] x);
        n_checks++;
        if (g !== x) begin
            n_mismatch++;
            $display("Error %0t: got %h want %h", $time, g, x);
        end
    endtask
    task automatic frame(input logic [3:0] a, input logic wr,
                         input logic [9:0] d, input int n, input bit bp);
        logic [15:0] s;
        logic [9:0]  rise;
        logic        dsr_old;
        s = st();
        e[15:11] = s[15:11];
        e[10:1] = wr ? s[10:1] : a == 4'h3 ? dcfg_m : a == 4'h6 ? sc_m :
            a == 4'hE ? msk : a == 4'hF ? {2'b00, lo} : s[10:1];
        e[0] = ~^e[15:1];
        ssd_host_i.xfer({a, wr, d, 1'b0}, n, bp, r);
        repeat (12) @(posedge i_clk);
        #1;
        chk_w(16'(oe_n), 16'h1);
        if (n == 16 && !bp) chk_w(r, e);
        else chk_w(16'({ssd_host_i.oe_low, r[15]}), 16'({1'b1, s[15]}));
        if (n == 16 && !bp) begin
            se_m = 1'b0;
            rise = d & ~sc_m;
            // the clear on this transfer follows the setting it was sent under
            dsr_old = sc_m[3];
            if (wr && a != 4'hF && cr) n_pa_m++;
            if (wr && a == 4'h3) dcfg_m = d;
            if (wr && a == 4'hE) msk = d;
            if (wr && a == 4'h6) sc_m = d;
            if (wr && a == 4'h6 && (rise[9] || rise[8])) clr(1);
            if (wr && !dsr_old) clr(0);
            if (!wr && a == 4'hF && !sc_m[3]) lo = oc;
        end else if (n != 0) se_m = 1'b1;
        s = st();
        chk_w(16'(dcfg), 16'(dcfg_m));
        chk_w(16'(sysc), 16'(sc_m));
        chk_w(16'(dpin), 16'(dcfg_m[8:6] == 3'h6 ? !sa : !s[15]));
    endtask
    task automatic test_done;
        if (n_mismatch == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ********
    // scenarios
    // ********
    initial begin
        #400000;
        n_mismatch++;
        test_done;
    end
    initial begin
        repeat (12) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        repeat (4) @(posedge i_clk);
        frame(4'h3, 0, 0, 0, 0);
        frame(4'h3, 0, 0, 16, 0);
        frame(4'h6, 0, 0, 16, 0);
        for (int k = 0; k < 4; k++) begin
            mon <= 6'($random(seed));
            oc <= 8'($random(seed));
            {cr, sa} <= 2'($random(seed));
            repeat (20) @(posedge i_clk);
            mon <= mon & 6'($random(seed));
            oc <= '0;
            repeat (20) @(posedge i_clk);
            frame(4'h3, 1, k == 0 ? 10'h180 : 10'($random(seed)), 16, 0);
            frame(4'h0, 1, 0, 16, 0);
            frame(4'hF, 0, 0, 16, 0);
        end
        foreach (bad[i]) begin
            frame(4'h3, 1, 10'h2AA, bad[i], i == 2);
            frame(4'h6, 0, 0, 16, 0);
        end
        frame(4'hF, 1, 10'h3FF, 16, 0);
        frame(4'hE, 1, 10'h3CC, 16, 0);
        mon <= 6'h3F;
        repeat (20) @(posedge i_clk);
        frame(4'h0, 1, 0, 16, 0);
        frame(4'hE, 1, 0, 16, 0);
        frame(4'h6, 1, 10'h028, 16, 0);
        oc <= 8'h18;
        mon <= '0;
        repeat (20) @(posedge i_clk);
        frame(4'h0, 1, 0, 16, 0);
        frame(4'hF, 0, 0, 16, 0);
        frame(4'h6, 1, 10'h128, 16, 0);
        frame(4'h6, 1, 10'h228, 16, 0);
        chk_w(16'(n_sl > 0), 16'h1);
        oc <= 8'h81;
        mon <= 6'h21;
        repeat (20) @(posedge i_clk);
        oc <= '0;
        mon <= 6'h01;
        rpin_n <= 1'b0;
        repeat (30) @(posedge i_clk);
        #1;
        chk_w(16'(slp), 16'h1);
        rpin_n <= 1'b1;
        repeat (10) @(posedge i_clk);
        #1;
        clr(1);
        frame(4'hF, 0, 0, 16, 0);
        chk_w(16'(n_pa), 16'(n_pa_m));
        test_done;
    end
endmodule
`default_nettype wire
